/* File: include/iwr_pkg.sv */
// constants and state types for the interval wake-up timer
package iwr_pkg;
    localparam int          XTAL_HZ       = 32768;
    localparam int          TICK_HZ       = 128;
    localparam int          PRESC_DIV     = XTAL_HZ / TICK_HZ;
    localparam logic [7:0]  PRESC_MAX     = 8'(PRESC_DIV - 1);
    localparam int          STAGES        = 4;
    // wrap values: fractional, seconds, minutes, hours
    localparam logic [3:0][7:0] STAGE_MAX = {8'h17, 8'h3b, 8'h3b, 8'h7f};
    localparam logic [15:0] WAKE_VECTOR   = 16'h0053;
    // control word bit positions
    localparam int          CTL_RUN       = 0;
    localparam int          CTL_CNT_EN    = 1;
    localparam int          CTL_FLAG      = 2;
    localparam int          CTL_ONE_SHOT  = 3;
    localparam int          CTL_SEL_LO    = 4;
    localparam int          CTL_SEL_HI    = 5;

    typedef struct packed {
        logic [1:0] xs;
        logic       xprev;
        logic [7:0] presc;
        logic       run;
        logic [1:0] sel;
        logic       one_shot;
        logic       flag;
        logic       cnt_en;
        logic [7:0] interval_compare_value;
        logic [7:0] icount;
    } iwr_state_t;

    typedef struct packed {
        logic [7:0] count;
    } iwr_stage_t;
endpackage

/* File: verilog/iwr_stage.sv */
// one wrapping time tally stage with load and carry
`timescale 1ns/1ps
module iwr_stage #(
    parameter logic [7:0] MAX = 8'h7f
) (
    // clock and clear
    input  wire logic       clk_in,
    input  wire logic       clear_in,
    // counting and loading
    input  wire logic       step_in,
    input  wire logic       load_in,
    input  wire logic [7:0] load_data_in,
    // tally
    output logic [7:0]      count_out,
    output logic            carry_out
);
    iwr_pkg::iwr_stage_t s_r;
    iwr_pkg::iwr_stage_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (clear_in) begin
            s_nxt.count = 8'h00;
        end else if (load_in) begin
            s_nxt.count = load_data_in;
        end else if (step_in) begin
            s_nxt.count = (s_r.count == MAX) ? 8'h00 : s_r.count + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        s_r <= s_nxt;
    end

    assign count_out = s_r.count;
    assign carry_out = step_in && (s_r.count == MAX);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (clear_in);

    stage_wrap_a : assert property (step_in && !load_in && s_r.count == MAX |=> s_r.count == 8'h00)
        else $error("stage did not wrap to zero after its top value");
    stage_step_a : assert property (step_in && !load_in && s_r.count < MAX
        |=> s_r.count == $past(s_r.count) + 8'h01)
        else $error("stage did not advance by one");
endmodule

/* File: verilog/iwr_timer.sv */
// interval wake-up timer and real-time tally chain
`timescale 1ns/1ps
// Behaviour
// - the tally chain and interval counter advance only from crystal edges, never from the system clock rate.
// - intervals range from one 1/128 s step up to 256 hours.
// - only fractional, seconds, minutes and hours are counted; days and beyond are software's job.
// - writes of the four tallies are accepted only while the run enable is low.
// - a reset while the run enable is set keeps the run enable and the four tallies.
// - a power cycle always clears the tallies, as does any reset while the run enable is clear.
// - the interval counter advances on each step of the stage picked by the two select bits.
// - a count equal to the compare value sets the match flag and requests an interrupt if enabled.
// - in power-down with the interrupt enabled, the match flag wakes the core to the interval vector.
// - with one-shot set a timeout clears the count enable, otherwise the counter reloads and restarts.
// - fractional counts 0..127, seconds and minutes 0..59, hours 0..23, each carrying into the next.
// - clearing the count enable stops the interval counter and zeroes it.
module iwr_timer (
    // clock and resets
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        power_on_reset_in,
    // crystal pin
    input  wire logic        xtal_clk_in,
    // control word write
    input  wire logic        ctrl_wr_in,
    input  wire logic [7:0]  ctrl_data_in,
    // compare value write
    input  wire logic        interval_compare_value_wr_in,
    input  wire logic [7:0]  interval_compare_value_data_in,
    // tally write
    input  wire logic        time_wr_in,
    input  wire logic [1:0]  time_sel_in,
    input  wire logic [7:0]  time_data_in,
    // core status
    input  wire logic        int_enable_in,
    input  wire logic        power_down_in,
    // readback
    output logic [7:0]       ctrl_out,
    output logic [7:0]       interval_compare_value_out,
    output logic [7:0]       interval_count_out,
    output logic [7:0]       fractional_out,
    output logic [7:0]       seconds_out,
    output logic [7:0]       minutes_out,
    output logic [7:0]       hours_out,
    // interrupt and wake
    output logic             irq_out,
    output logic             wake_out,
    output logic [15:0]      vector_out
);
    iwr_pkg::iwr_state_t s_r;
    iwr_pkg::iwr_state_t s_nxt;

    logic                                xtal_rise;
    logic                                tick128;
    logic                                stage_clear;
    logic [iwr_pkg::STAGES-1:0]          stage_step;
    logic [iwr_pkg::STAGES-1:0]          stage_carry;
    logic [iwr_pkg::STAGES-1:0]          stage_load;
    logic [iwr_pkg::STAGES-1:0][7:0]     tally;
    logic                                int_step;
    logic [7:0]                          icount_inc;
    logic                                timeout;
    logic                                flag_clear;

    assign xtal_rise   = s_r.xs[1] && !s_r.xprev;
    assign tick128     = xtal_rise && s_r.run && (s_r.presc == iwr_pkg::PRESC_MAX);
    assign stage_clear = power_on_reset_in || (reset_in && !s_r.run);

    // tally chain, each overflow stepping the next stage
    genvar i;
    generate
        for (i = 0; i < iwr_pkg::STAGES; i++) begin : g_stage
            if (i == 0) begin : g_first
                assign stage_step[i] = tick128;
            end else begin : g_next
                assign stage_step[i] = stage_carry[i-1];
            end
            assign stage_load[i] = time_wr_in && !s_r.run && (time_sel_in == 2'(i));
            iwr_stage #(
                .MAX          (iwr_pkg::STAGE_MAX[i])
            ) u_stage (
                .clk_in       (clk_in),
                .clear_in     (stage_clear),
                .step_in      (stage_step[i]),
                .load_in      (stage_load[i]),
                .load_data_in (time_data_in),
                .count_out    (tally[i]),
                .carry_out    (stage_carry[i])
            );
        end
    endgenerate

    // select 0 rides the 1/128 s tick, higher codes the overflow of the stage below
    assign int_step   = s_r.cnt_en && stage_step[s_r.sel];
    assign icount_inc = s_r.icount + 8'h01;
    assign timeout    = int_step && (icount_inc == s_r.interval_compare_value);
    assign flag_clear = ctrl_wr_in && !ctrl_data_in[iwr_pkg::CTL_FLAG];

    always_comb begin
        s_nxt       = s_r;
        s_nxt.xs    = {s_r.xs[0], xtal_clk_in};
        s_nxt.xprev = s_r.xs[1];
        if (!s_r.run) begin
            s_nxt.presc = 8'h00;
        end else if (xtal_rise) begin
            s_nxt.presc = s_r.presc + 8'h01;
        end
        if (ctrl_wr_in) begin
            s_nxt.run      = ctrl_data_in[iwr_pkg::CTL_RUN];
            s_nxt.cnt_en   = ctrl_data_in[iwr_pkg::CTL_CNT_EN];
            s_nxt.one_shot = ctrl_data_in[iwr_pkg::CTL_ONE_SHOT];
            s_nxt.sel      = ctrl_data_in[iwr_pkg::CTL_SEL_HI:iwr_pkg::CTL_SEL_LO];
        end
        if (interval_compare_value_wr_in) begin
            s_nxt.interval_compare_value = interval_compare_value_data_in;
        end
        // sticky flag, set beats clear
        s_nxt.flag = timeout || (s_r.flag && !flag_clear);
        if (!s_r.cnt_en) begin
            s_nxt.icount = 8'h00;
        end else if (timeout) begin
            s_nxt.icount = 8'h00;
            if (s_r.one_shot) begin
                s_nxt.cnt_en = 1'b0;
            end
        end else if (int_step) begin
            s_nxt.icount = icount_inc;
        end
        if (power_on_reset_in) begin
            s_nxt = '0;
        end else if (reset_in) begin
            s_nxt.run      = s_r.run;
            s_nxt.presc    = s_r.run ? s_nxt.presc : 8'h00;
            s_nxt.sel      = 2'h0;
            s_nxt.one_shot = 1'b0;
            s_nxt.flag     = 1'b0;
            s_nxt.cnt_en   = 1'b0;
            s_nxt.interval_compare_value   = 8'h00;
            s_nxt.icount   = 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        s_r <= s_nxt;
    end

    assign ctrl_out           = {2'b00, s_r.sel, s_r.one_shot, s_r.flag, s_r.cnt_en, s_r.run};
    assign interval_compare_value_out         = s_r.interval_compare_value;
    assign interval_count_out = s_r.icount;
    assign fractional_out     = tally[0];
    assign seconds_out        = tally[1];
    assign minutes_out        = tally[2];
    assign hours_out          = tally[3];
    assign irq_out            = s_r.flag && int_enable_in;
    assign wake_out           = power_down_in && int_enable_in && s_r.flag;
    assign vector_out         = iwr_pkg::WAKE_VECTOR;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (power_on_reset_in);

    sequence timeout_s;
        timeout && !reset_in;
    endsequence
    sequence reloaded_s;
        s_r.icount == 8'h00 && s_r.flag;
    endsequence
    sequence presc_wrap_s;
        s_r.run && xtal_rise && s_r.presc == iwr_pkg::PRESC_MAX;
    endsequence
    sequence auto_reload_s;
        timeout_s ##0 !s_r.one_shot && !ctrl_wr_in;
    endsequence

    run_hold_a : assert property (reset_in && s_r.run && !tick128 |=> s_r.run && $stable(tally))
        else $error("run enable or tallies lost across reset");
    reset_clear_a : assert property (reset_in && !s_r.run |=> tally == '0)
        else $error("tallies not cleared by reset with run low");
    write_block_a : assert property (time_wr_in && s_r.run && !tick128 && !reset_in |=> $stable(tally))
        else $error("tally changed by a write while running");
    write_take_a : assert property (time_wr_in && !s_r.run && !reset_in
        |=> tally[$past(time_sel_in)] == $past(time_data_in))
        else $error("tally write not taken while stopped");
    stopped_chain_a : assert property (!s_r.run && !time_wr_in && !reset_in |=> $stable(tally))
        else $error("tallies moved without crystal timebase");
    int_step_a : assert property (int_step && !timeout && !reset_in |=> s_r.icount == $past(icount_inc))
        else $error("interval counter missed a selected overflow");
    match_reload_a : assert property (timeout_s |=> reloaded_s)
        else $error("match did not set flag and reload counter");
    one_shot_a : assert property (timeout_s ##0 s_r.one_shot |=> !s_r.cnt_en ##1 s_r.icount == 8'h00)
        else $error("one-shot timeout left count enable set");
    stop_clear_a : assert property (!s_r.cnt_en |=> s_r.icount == 8'h00)
        else $error("disabled interval counter not zero");
    flag_sticky_a : assert property (s_r.flag && !flag_clear && !reset_in |=> s_r.flag)
        else $error("match flag dropped without software clear");
    wake_a : assert property (power_down_in && int_enable_in && s_r.flag |-> wake_out && irq_out)
        else $error("flag did not wake core in power-down");

    presc_stop_a : assert property (!s_r.run |=> s_r.presc == 8'h00)
        else $error("prescaler not held at zero while stopped");
    presc_step_a : assert property (s_r.run && xtal_rise |=> s_r.presc == $past(s_r.presc) + 8'h01)
        else $error("prescaler missed a crystal edge");
    presc_hold_a : assert property (s_r.run && !xtal_rise |=> $stable(s_r.presc))
        else $error("prescaler moved without a crystal edge");
    presc_wrap_a : assert property (presc_wrap_s |-> tick128 ##1 s_r.presc == 8'h00)
        else $error("prescaler wrap gave no 1/128 s tick");
    day_drop_a : assert property (stage_carry[iwr_pkg::STAGES-1] |=> tally[iwr_pkg::STAGES-1] == 8'h00)
        else $error("hours did not wrap to zero");
    fast_step_a : assert property (s_r.cnt_en && s_r.sel == 2'h0 && tick128 && !timeout && !reset_in
        |=> s_r.icount == $past(s_r.icount) + 8'h01)
        else $error("interval counter missed a 1/128 s tick");
    icount_hold_a : assert property (s_r.cnt_en && !int_step && !reset_in |=> $stable(s_r.icount))
        else $error("interval counter moved without a selected overflow");
    flag_rise_a : assert property ($rose(s_r.flag) |-> $past(timeout))
        else $error("match flag set without a match");
    reload_keep_a : assert property (auto_reload_s |=> s_r.cnt_en && s_r.icount == 8'h00)
        else $error("periodic timeout did not reload and keep counting");
    reset_ctl_a : assert property (reset_in |=> !s_r.cnt_en && !s_r.flag && s_r.interval_compare_value == 8'h00)
        else $error("interval controls kept across reset");
endmodule

/* File: sim/tb.sv */
// self-checking testbench for the interval wake-up timer
`timescale 1ns/1ps
module tb;
    logic             clk_in = 1'b0;
    logic             reset_in = 1'b1;
    logic             power_on_reset_in = 1'b1;
    logic             xtal_clk_in = 1'b0;
    logic             ctrl_wr_in = 1'b0;
    logic [7:0]       ctrl_data_in = 8'h00;
    logic             interval_compare_value_wr_in = 1'b0;
    logic [7:0]       interval_compare_value_data_in = 8'h00;
    logic             time_wr_in = 1'b0;
    logic [1:0]       time_sel_in = 2'h0;
    logic [7:0]       time_data_in = 8'h00;
    logic             int_enable_in = 1'b0;
    logic             power_down_in = 1'b0;
    logic [7:0]       ctrl_out, interval_compare_value_out, interval_count_out;
    logic [7:0]       fractional_out, seconds_out, minutes_out, hours_out;
    logic             irq_out, wake_out;
    logic [15:0]      vector_out;
    logic [3:0][7:0]  tal, v;
    int               n_errors = 0;
    int               tests_run = 0;

    iwr_timer DUT (.clk_in(clk_in), .reset_in(reset_in), .power_on_reset_in(power_on_reset_in),
        .xtal_clk_in(xtal_clk_in), .ctrl_wr_in(ctrl_wr_in), .ctrl_data_in(ctrl_data_in),
        .interval_compare_value_wr_in(interval_compare_value_wr_in), .interval_compare_value_data_in(interval_compare_value_data_in), .time_wr_in(time_wr_in),
        .time_sel_in(time_sel_in), .time_data_in(time_data_in), .int_enable_in(int_enable_in),
        .power_down_in(power_down_in), .ctrl_out(ctrl_out), .interval_compare_value_out(interval_compare_value_out),
        .interval_count_out(interval_count_out), .fractional_out(fractional_out),
        .seconds_out(seconds_out), .minutes_out(minutes_out), .hours_out(hours_out),
        .irq_out(irq_out), .wake_out(wake_out), .vector_out(vector_out));

    assign tal = {hours_out, minutes_out, seconds_out, fractional_out};

    always #5 clk_in = ~clk_in;

    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // k: 0 control, 1 compare value, 2 tally
    task wr(input int k, input logic [7:0] d, input logic [1:0] s);
        @(posedge clk_in);
        ctrl_wr_in <= (k == 0);
        interval_compare_value_wr_in <= (k == 1);
        time_wr_in <= (k == 2);
        ctrl_data_in <= d;
        interval_compare_value_data_in <= d;
        time_data_in <= d;
        time_sel_in <= s;
        @(posedge clk_in);
        ctrl_wr_in <= 1'b0;
        interval_compare_value_wr_in <= 1'b0;
        time_wr_in <= 1'b0;
        @(negedge clk_in);
    endtask

    task set_tal(input logic [3:0][7:0] t);
        for (int i = 0; i < 4; i++) wr(2, t[i], 2'(i));
    endtask

    // n crystal rising edges, two clocks high and two low
    task xt(input int n);
        repeat (n) begin
            @(posedge clk_in);
            xtal_clk_in <= 1'b1;
            repeat (2) @(posedge clk_in);
            xtal_clk_in <= 1'b0;
            @(posedge clk_in);
        end
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task pulse(input bit por);
        @(posedge clk_in);
        if (por) power_on_reset_in <= 1'b1;
        else reset_in <= 1'b1;
        @(posedge clk_in);
        power_on_reset_in <= 1'b0;
        reset_in <= 1'b0;
        @(negedge clk_in);
    endtask

    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        void'($urandom(15));
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        power_on_reset_in <= 1'b0;
        for (int i = 0; i < 4; i++) v[i] = 8'($urandom_range(0, (i == 3) ? 23 : 57));
        set_tal(v);
        wr(0, 8'hc0, 2'h0);
        chk("tallies", tal, v);
        chk("ctrl", ctrl_out, 8'h00);
        $display("test load done");
        wr(0, 8'h01, 2'h0);
        wr(2, 8'h3a, 2'($urandom_range(0, 3)));
        chk("tallies", tal, v);
        pulse(1'b0);
        chk("tallies", tal, v);
        chk("ctrl", ctrl_out, 8'h01);
        $display("test hold done");
        @(posedge clk_in);
        int_enable_in <= 1'b1;
        power_down_in <= 1'b1;
        wr(1, 8'h02, 2'h0);
        chk("interval_compare_value", interval_compare_value_out, 8'h02);
        wr(0, 8'h0b, 2'h0);
        xt(256);
        chk("count", interval_count_out, 8'h01);
        chk("irq", irq_out, 1'b0);
        xt(256);
        chk("ctrl", ctrl_out, 8'h0d);
        chk("irq", irq_out, 1'b1);
        chk("wake", wake_out, 1'b1);
        chk("vector", vector_out, 16'h0053);
        chk("frac", fractional_out, v[0] + 8'h02);
        $display("test oneshot done");
        wr(0, 8'h07, 2'h0);
        chk("ctrl", ctrl_out, 8'h07);
        @(posedge clk_in);
        power_down_in <= 1'b0;
        @(negedge clk_in);
        chk("wake", wake_out, 1'b0);
        chk("irq", irq_out, 1'b1);
        xt(256);
        chk("count", interval_count_out, 8'h01);
        wr(0, 8'h01, 2'h0);
        @(negedge clk_in);
        chk("count", interval_count_out, 8'h00);
        chk("irq", irq_out, 1'b0);
        $display("test clear done");
        for (int s = 0; s < 4; s++) begin
            wr(0, 8'h00, 2'h0);
            for (int i = 0; i < 4; i++) v[i] = (i <= s) ? iwr_pkg::STAGE_MAX[i] : 8'h00;
            set_tal(v);
            wr(1, 8'h01, 2'h0);
            wr(0, 8'h03 | 8'(s << 4), 2'h0);
            xt(256);
            for (int i = 0; i < 4; i++) v[i] = (i == s + 1) ? 8'h01 : 8'h00;
            chk("tallies", tal, v);
            chk("ctrl", ctrl_out, 8'h07 | 8'(s << 4));
        end
        $display("test select done");
        wr(0, 8'h00, 2'h0);
        v = {8'h05, 8'h06, 8'h07, 8'h08};
        set_tal(v);
        pulse(1'b0);
        chk("tallies", tal, 32'h0);
        set_tal(v);
        wr(0, 8'h01, 2'h0);
        pulse(1'b1);
        chk("tallies", tal, 32'h0);
        chk("ctrl", ctrl_out, 8'h00);
        $display("test reset done");
        end_sim;
    end

    // tests need about 7400 cycles
    initial begin
        repeat (50000) @(posedge clk_in);
        n_errors++;
        end_sim;
    end
endmodule
